// >>> verilog/sfpu_pkg.sv
// Package: constants and types for the serial flash power-up sequencer
package sfpu_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned PUW_TIME_US     = 3000;  // program/erase power-up delay, max 3 ms
  localparam int unsigned PUW_CYCLES      = PUW_TIME_US * CLK_MHZ;
  localparam int unsigned VCSL_TIME_US    = 70;    // supply to select low, read
  localparam int unsigned VCSL_CYCLES     = VCSL_TIME_US * CLK_MHZ;
  localparam int unsigned SYNC_STAGES     = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic        RST_SO_OE       = 1'b0;
  localparam logic        RST_MODE3       = 1'b0;
  localparam logic [2:0]  RST_LINK        = 3'h7;  // sck, select, data all seen high

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SFPU_POR     = 2'b00,
    SFPU_WAIT    = 2'b01,
    SFPU_STANDBY = 2'b10,
    SFPU_ACTIVE  = 2'b11
  } sfpu_state_e;

  typedef struct packed {
    logic sck;
    logic chip_select_n;
    logic si;
  } sfpu_link_s;

  typedef struct packed {
    logic so_out;
    logic so_oe;
  } sfpu_so_s;

endpackage : sfpu_pkg

// >>> verilog/sfpu_sync.sv
// Two-flop synchroniser for a group of link pins
`timescale 1ns/1ps
module sfpu_sync #(
  parameter int unsigned      WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  initial
  begin
    if (WIDTH < 1) $error("sfpu_sync: WIDTH must be at least 1");
  end

  // Reset to the caller's idle levels, so no false edge follows reset
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta   <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule : sfpu_sync

// >>> verilog/sfpu_top.sv
// Top: power-on / reset entry sequencer of a serial flash device
`timescale 1ns/1ps
module sfpu_top
  import sfpu_pkg::*;
#(
  parameter int unsigned PUW_CYC  = sfpu_pkg::PUW_CYCLES,
  parameter int unsigned VCSL_CYC = sfpu_pkg::VCSL_CYCLES
) (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_B,
  input  wire logic        I_POR_ACTIVE,
  input  wire logic        I_SCK,
  input  wire logic        I_CHIP_SELECT_N,
  input  wire logic        I_SI,
  input  wire logic        I_CMD_DRIVE_SO,
  input  wire logic        I_CMD_SO_DATA,
  output logic             O_SO,
  output logic             O_SO_OE,
  output logic             O_MODE3,
  output logic             O_FRAME_START,
  output logic             O_CMD_ENABLE,
  output logic             O_READ_ALLOWED,
  output logic             O_PGM_ERASE_ALLOWED,
  output logic [1:0]       O_STATE
);
  import sfpu_pkg::*;

  initial
  begin
    if (PUW_CYC < 1 || VCSL_CYC < 1) $error("sfpu_top: counts must be at least 1");
    if (VCSL_CYC > PUW_CYC) $error("sfpu_top: read wait must not exceed program wait");
  end

  // ****************************************
  // Pin synchronisation
  // ****************************************
  sfpu_link_s link_raw;
  sfpu_link_s link;
  logic       por_meta;
  logic       por_sync;

  assign link_raw = '{sck: I_SCK, chip_select_n: I_CHIP_SELECT_N, si: I_SI};

  sfpu_sync #(.WIDTH(3), .RST_VAL(RST_LINK)) u_sync (
    .i_clk     (I_CLK_SYS),
    .i_rst_b   (I_RST_B),
    .i_async   (link_raw),
    .o_sync    (link)
  );

  // POR detector output is asynchronous; held active while in reset
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      por_meta <= 1'b1;
      por_sync <= 1'b1;
    end
    else
    begin
      por_meta <= I_POR_ACTIVE;
      por_sync <= por_meta;
    end
  end

  // ****************************************
  // Select falling and rising edge detection
  // ****************************************
  logic cs_prev;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      cs_prev <= 1'b1;
    else
      cs_prev <= link.chip_select_n;
  end

  assign cs_fall = cs_prev & ~link.chip_select_n;
  assign cs_rise = ~cs_prev & link.chip_select_n;

  // ****************************************
  // Power-up sequencer
  // ****************************************
  sfpu_state_e state;
  sfpu_state_e next_state;
  logic [31:0] puw_cnt;
  logic        armed;

  always_comb
  begin
    next_state = state;
    case (state)
      SFPU_POR:
        if (!por_sync) next_state = SFPU_WAIT;
      SFPU_WAIT:
        if (puw_cnt >= 32'(PUW_CYC - 1))
          next_state = link.chip_select_n ? SFPU_STANDBY : SFPU_ACTIVE;
      SFPU_STANDBY:
        if (cs_fall) next_state = SFPU_ACTIVE;
      SFPU_ACTIVE:
        if (cs_rise) next_state = SFPU_STANDBY;
      default:
        next_state = SFPU_POR;
    endcase
    if (por_sync) next_state = SFPU_POR;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      state <= SFPU_POR;
    else
      state <= next_state;
  end

  // Counter saturates so the wait flag never wraps
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      puw_cnt <= 32'h0;
    else if (por_sync)
      puw_cnt <= 32'h0;
    else if (puw_cnt != 32'hffffffff)
      puw_cnt <= puw_cnt + 32'h1;
  end

  // A frame already low when power-on reset ends is not a valid start
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      armed <= 1'b0;
    else if (next_state == SFPU_POR)
      armed <= 1'b0;
    else if (cs_fall && state != SFPU_POR)
      armed <= 1'b1;
    else if (cs_rise)
      armed <= 1'b0;
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
      O_MODE3 <= RST_MODE3;
    else if (cs_fall && !por_sync)
      O_MODE3 <= link.sck;
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_SO    <= 1'b0;
      O_SO_OE <= RST_SO_OE;
    end
    else
    begin
      O_SO    <= I_CMD_SO_DATA;
      O_SO_OE <= I_CMD_DRIVE_SO & armed & ~link.chip_select_n & ~por_sync;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_FRAME_START       <= 1'b0;
      O_CMD_ENABLE        <= 1'b0;
      O_READ_ALLOWED      <= 1'b0;
      O_PGM_ERASE_ALLOWED <= 1'b0;
      O_STATE             <= SFPU_POR;
    end
    else
    begin
      O_FRAME_START       <= cs_fall & ~por_sync;
      O_CMD_ENABLE        <= armed & ~link.chip_select_n & ~por_sync;
      O_READ_ALLOWED      <= ~por_sync & (puw_cnt >= 32'(VCSL_CYC - 1));
      O_PGM_ERASE_ALLOWED <= ~por_sync & (puw_cnt >= 32'(PUW_CYC - 1));
      O_STATE             <= next_state;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_so_quiet_por: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    por_sync |=> !O_SO_OE)
    else $error("SO driven during power-on reset");

  a_so_needs_frame: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    O_SO_OE |-> $past(armed) && !$past(link.chip_select_n))
    else $error("SO driven without framed command");

  a_mode_sample: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (cs_fall && !por_sync) |=> O_MODE3 == $past(link.sck))
    else $error("Mode not taken from idle clock");

  a_cmd_blocked: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    por_sync |=> !O_CMD_ENABLE && !O_FRAME_START)
    else $error("Command enabled during power-on reset");

  a_pgm_wait: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    O_PGM_ERASE_ALLOWED |-> $past(puw_cnt) >= 32'(PUW_CYC - 1))
    else $error("Program allowed before delay");

  a_read_wait: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    O_READ_ALLOWED |-> $past(puw_cnt) >= 32'(VCSL_CYC - 1))
    else $error("Read allowed before wait");

  a_exit_state: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    (state == SFPU_WAIT && puw_cnt >= 32'(PUW_CYC - 1) && !por_sync) |=>
      state == ($past(link.chip_select_n) ? SFPU_STANDBY : SFPU_ACTIVE))
    else $error("Wrong state after delay");

  a_por_state: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    por_sync |=> state == SFPU_POR)
    else $error("Left reset state early");

  c_mode3: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    cs_fall && link.sck);
  c_mode0: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    cs_fall && !link.sck);
  c_standby: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    state == SFPU_WAIT ##1 state == SFPU_STANDBY);
  c_so_drive: cover property (@(posedge I_CLK_SYS) disable iff (!I_RST_B)
    O_SO_OE);

endmodule : sfpu_top

// >>> test/sfpu_host_model.sv
// Host controller model driving the link pins
`timescale 1ns/1ps
module sfpu_host_model (
  input  wire logic           i_clk,
  output sfpu_pkg::sfpu_link_s o_link
);
  import sfpu_pkg::*;
  logic busy = 1'b0;
  initial
    o_link = '{sck: 1'b0, chip_select_n: 1'b1, si: 1'b0};
  // Data toggles outside frames so no stale bit looks valid
  always @(negedge i_clk)
    if (!busy)
      o_link.si <= ~o_link.si;
  task automatic select(input logic lvl);
    @(negedge i_clk);
    o_link.chip_select_n = lvl;
  endtask : select
  task automatic frame(input logic idle, input int nbits);
    busy = 1'b1;
    @(negedge i_clk);
    o_link.sck = idle;
    repeat (4) @(negedge i_clk);
    o_link.chip_select_n = 1'b0;
    repeat (2 * nbits)
    begin
      o_link.si = 1'($urandom);
      repeat (8) @(negedge i_clk);
      o_link.sck = ~o_link.sck;
    end
    repeat (8) @(negedge i_clk);
    o_link.chip_select_n = 1'b1;
    repeat (4) @(negedge i_clk);
    busy = 1'b0;
  endtask : frame
endmodule : sfpu_host_model

// >>> test/tb.sv
// Self-checking bench for the power-up sequencer
`timescale 1ns/1ps
module tb;
  import sfpu_pkg::*;
  localparam int unsigned PUW  = 50;
  localparam int unsigned VCSL = 20;
  logic       clk = 1'b0, rst_b = 1'b0, por = 1'b1, drv = 1'b0, dat = 1'b0;
  logic       so, so_oe, mode3, fstart, cmd_en, rd_ok, pe_ok;
  logic [1:0] state;
  sfpu_link_s link;
  int         error_cnt = 0;
  int         comparisons = 0;
  logic       expq [$];
  always #5 clk = ~clk;
  sfpu_host_model host_u (.i_clk(clk), .o_link(link));
  sfpu_top #(.PUW_CYC(PUW), .VCSL_CYC(VCSL)) dut_u (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_POR_ACTIVE(por), .I_SCK(link.sck),
    .I_CHIP_SELECT_N(link.chip_select_n), .I_SI(link.si), .I_CMD_DRIVE_SO(drv),
    .I_CMD_SO_DATA(dat), .O_SO(so), .O_SO_OE(so_oe), .O_MODE3(mode3),
    .O_FRAME_START(fstart), .O_CMD_ENABLE(cmd_en), .O_READ_ALLOWED(rd_ok),
    .O_PGM_ERASE_ALLOWED(pe_ok), .O_STATE(state));
  task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // Every frame start must match a note left by the driver
  always @(negedge clk)
    if (fstart === 1'b1)
    begin
      if (expq.size() == 0)
        chk("frame_start", 2'b01, 2'b00);
      else
        chk("mode3", {1'b0, mode3}, {1'b0, expq.pop_front()});
    end
  task automatic framed(input logic idle, input logic live);
    if (live)
      expq.push_back(idle);
    fork
      host_u.frame(idle, 2);
      begin
        repeat (20) @(negedge clk);
        chk("cmd_en", {1'b0, cmd_en}, {1'b0, live});
        chk("so_oe", {1'b0, so_oe}, {1'b0, live & drv});
        if (live & drv)
          chk("so", {1'b0, so}, {1'b0, dat});
      end
    join
  endtask : framed
  task automatic power_up(input logic [1:0] exp_state);
    int n;
    n = 0;
    por = 1'b0;
    while (rd_ok !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("read_ok", {1'b0, rd_ok}, 2'b01);
    chk("read_wait", 2'(n >= VCSL && n <= VCSL + 8), 2'b01);
    chk("pe_early", {1'b0, pe_ok}, 2'b00);
    while (pe_ok !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("pe_wait", 2'(n >= PUW && n <= PUW + 8), 2'b01);
    @(negedge clk);
    chk("state", state, exp_state);
  endtask : power_up
  initial
  begin
    #100us;
    error_cnt++;
    conclude();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(87));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    chk("so_oe_rst", {1'b0, so_oe}, 2'b00);
    chk("state_rst", state, 2'b00);
    drv = 1'b1;
    framed(1'b1, 1'b0);
    power_up(2'b10);
    for (int i = 0; i < 6; i++)
    begin
      drv = (i % 3 != 2);
      dat = 1'($urandom);
      framed(i[0], 1'b1);
    end
    chk("pending", 2'(expq.size()), 2'b00);
    drv = 1'b1;
    por = 1'b1;
    host_u.select(1'b0);
    repeat (5) @(negedge clk);
    power_up(2'b11);
    chk("unarmed", {1'b0, cmd_en}, 2'b00);
    chk("unarmed_so", {1'b0, so_oe}, 2'b00);
    host_u.select(1'b1);
    repeat (5) @(negedge clk);
    conclude();
  end
endmodule : tb
